// ===== verilog/microprogram_sequencer_control.sv
// microprogram sequencer, control stores, entry map and pipeline register
// assumes datapath status and opcode inputs are on clk_in; straps are pins
`timescale 1ns/100ps
`default_nettype none
module microprogram_sequencer_control
  import useq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic speed_fast_in,
  input wire logic extended_instruction_option_in,
  input wire logic wcs_fitted_in,
  input wire logic [15:0] internal_word_bus_in,
  input wire logic instr_load_in,
  input wire logic ring_msb_in,
  input wire logic [STATUS_W-1:0] status_in,
  input wire logic store_wr_en_in,
  input wire logic [1:0] store_wr_sel_in,
  input wire logic [11:0] store_wr_addr_in,
  input wire logic [WORD_W-1:0] store_wr_data_in,
  output logic [DIRECT_W-1:0] direct_ctl_out,
  output logic [DEC_LINES-1:0] decoded_ctl_out,
  output logic [UADDR_W-1:0] uaddr_out,
  output logic [10:0] instruction_register_out,
  output logic microcycle_out
);
  // ----------------------------------------------------------------------
  // memories
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] prom [0:PROM_WORDS-1];
  logic [WORD_W-1:0] wcs [0:WCS_WORDS-1];
  logic [MAP_W-1:0] entry_map [0:MAP_WORDS-1];

  // loaded by the image port before the sequencer is let run; the prom
  // half is read-only to microcode, only the wcs is meant for live writes
  always_ff @(posedge clk_in)
  begin
    if (store_wr_en_in && store_wr_sel_in == SEL_PROM)
      prom[store_wr_addr_in] <= store_wr_data_in;
    if (store_wr_en_in && store_wr_sel_in == SEL_WCS)
      wcs[store_wr_addr_in[7:0]] <= store_wr_data_in;
    if (store_wr_en_in && store_wr_sel_in == SEL_MAP)
      entry_map[store_wr_addr_in[10:0]] <= store_wr_data_in[MAP_W-1:0];
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] next_pin_meta;

  always_comb
  begin
    next_pin_meta = {speed_fast_in, extended_instruction_option_in,
                     wcs_fitted_in};
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= pin_meta;
    end
  end

  logic fast_mode;
  logic ext_fitted;
  logic wcs_fitted;
  assign fast_mode = pin_sync[2];
  assign ext_fitted = pin_sync[1];
  assign wcs_fitted = pin_sync[0];

  // ----------------------------------------------------------------------
  // microcycle divider
  // ----------------------------------------------------------------------
  logic [5:0] cyc_cnt;
  logic [5:0] next_cyc_cnt;
  logic tick;
  logic next_microcycle;

  always_comb
  begin
    tick = (cyc_cnt == 6'h00);
    next_microcycle = tick;
    if (tick)
      next_cyc_cnt = fast_mode ? 6'(FAST_CYCLES - 6'h01)
                               : 6'(SLOW_CYCLES - 6'h01);
    else
      next_cyc_cnt = 6'(cyc_cnt - 6'h01);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_cnt <= 6'h00;
      microcycle_out <= 1'b0;
    end
    else
    begin
      cyc_cnt <= next_cyc_cnt;
      microcycle_out <= next_microcycle;
    end
  end

  // ----------------------------------------------------------------------
  // instruction register and entry map
  // ----------------------------------------------------------------------
  logic [15:0] instr;
  logic [15:0] next_instr;
  logic [10:0] map_addr;
  logic [MAP_W-1:0] map_entry;

  always_comb
  begin
    next_instr = instr;
    if (instr_load_in)
      next_instr = internal_word_bus_in;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      instr <= 16'h0000;
    else
      instr <= next_instr;
  end

  // upper table half holds the full set, lower half the unprivileged one
  assign map_addr = {ring_msb_in, instr[15:6]};
  assign map_entry = entry_map[map_addr];
  assign instruction_register_out = instr[10:0];

  // ----------------------------------------------------------------------
  // control store read
  // ----------------------------------------------------------------------
  logic [UADDR_W-1:0] upc;
  logic [WORD_W-1:0] store_word;

  always_comb
  begin
    if (upc[WCS_SEL_BIT])
      store_word = wcs_fitted ? wcs[upc[7:0]] : NOP_WORD;
    else if (upc[11] && !ext_fitted)
      store_word = NOP_WORD;
    else
      store_word = prom[upc[11:0]];
  end

  // ----------------------------------------------------------------------
  // next address selection
  // ----------------------------------------------------------------------
  seq_op_e op;
  logic cond_true;
  logic [UADDR_W-1:0] branch_addr;
  logic [UADDR_W-1:0] upc_inc;
  logic [UADDR_W-1:0] stack_top;
  logic [UADDR_W-1:0] next_upc;
  logic push;
  logic pop;

  // sequence fields come from the store output, not the pipeline
  assign branch_addr = store_word[BR_HI:BR_LO];
  assign upc_inc = UADDR_W'(upc + 13'h0001);

  always_comb
  begin
    op = seq_op_e'(store_word[OP_HI:OP_LO]);
    // status select and polarity come from the store output word, not the pipeline
    cond_true = status_in[store_word[COND_HI:COND_LO]]
                ^ store_word[POL_BIT];
    next_upc = upc;
    push = 1'b0;
    pop = 1'b0;
    if (tick)
    begin
      unique case (op)
        OP_CONT: next_upc = upc_inc;
        OP_JUMP: next_upc = branch_addr;
        OP_CJUMP: next_upc = cond_true ? branch_addr : upc_inc;
        OP_CALL:
        begin
          next_upc = branch_addr;
          push = 1'b1;
        end
        OP_CCALL:
        begin
          next_upc = cond_true ? branch_addr : upc_inc;
          push = cond_true;
        end
        OP_RET:
        begin
          next_upc = stack_top;
          pop = 1'b1;
        end
        OP_CRET:
        begin
          next_upc = cond_true ? stack_top : upc_inc;
          pop = cond_true;
        end
        OP_MAPJ: next_upc = {1'b0, map_entry};
        OP_HOLD: next_upc = upc;
        // unused opcodes fall through as plain continue
        default: next_upc = upc_inc;
      endcase
    end
  end

  return_stack u_stack (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .push_in(push),
    .pop_in(pop),
    .push_data_in(upc_inc),
    .top_out(stack_top)
  );

  // ----------------------------------------------------------------------
  // pipeline register and control decode
  // ----------------------------------------------------------------------
  logic [DIRECT_W-1:0] next_direct;
  logic [DEC_LINES-1:0] next_decoded;

  always_comb
  begin
    next_direct = direct_ctl_out;
    next_decoded = decoded_ctl_out;
    if (tick)
    begin
      next_direct = store_word[DIRECT_HI:0];
      next_decoded = DEC_LINES'(8'h01 << store_word[DEC_HI:DEC_LO]);
    end
  end

  // sequencer and pipeline share the same tick edge, so the next fetch
  // overlaps the data operation of the word now held
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      upc <= RESET_UADDR;
      direct_ctl_out <= NOP_WORD[DIRECT_HI:0];
      decoded_ctl_out <= 8'h00;
      uaddr_out <= RESET_UADDR;
    end
    else
    begin
      upc <= next_upc;
      direct_ctl_out <= next_direct;
      decoded_ctl_out <= next_decoded;
      uaddr_out <= next_upc;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/useq_pkg.sv
// constants and types for the microprogram sequencer and control store
// assumes a single 200 MHz clock; the datapath supplies status and opcodes
// ----------------------------------------------------------------------
// Operation
// - base control store: 2048 words of 64 bits
// - store expands to 4096 words with option
// - optional 256-word writable store is addressable
// - map addressed by instruction bits six to fifteen
// - map output loads sequencer as next address
// - pipeline register holds executing microinstruction
// - next address from sequence field plus status
// - return stack for microcode calls and returns
// - branch field feeds sequencer, bypassing pipeline
// - other bits drive or decode control lines
// - sequencer and pipeline load on same edge
// - one microcycle from load to next input
// - map is 2048 entries of 12 bits
// - ring bit selects full or unprivileged table
// - microcycle lasts 190 or 150 ns
// ----------------------------------------------------------------------
package useq_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SLOW_CYCLE_NS = 190;
  localparam int FAST_CYCLE_NS = 150;
  localparam logic [5:0] SLOW_CYCLES = 6'(SLOW_CYCLE_NS / CLK_PERIOD_NS);
  localparam logic [5:0] FAST_CYCLES = 6'(FAST_CYCLE_NS / CLK_PERIOD_NS);

  localparam int WORD_W = 64;
  localparam int UADDR_W = 13;
  localparam int PROM_WORDS = 4096;
  localparam int PROM_BASE_WORDS = 2048;
  localparam int WCS_WORDS = 256;
  localparam int MAP_WORDS = 2048;
  localparam int MAP_W = 12;
  localparam int STACK_DEPTH = 8;

  // microinstruction field layout
  localparam int OP_HI = 63;
  localparam int OP_LO = 60;
  localparam int COND_HI = 59;
  localparam int COND_LO = 56;
  localparam int POL_BIT = 55;
  localparam int BR_HI = 54;
  localparam int BR_LO = 42;
  localparam int DEC_HI = 41;
  localparam int DEC_LO = 39;
  localparam int DIRECT_HI = 38;
  localparam int DIRECT_W = 39;
  localparam int DEC_LINES = 8;
  localparam int STATUS_W = 16;
  localparam int WCS_SEL_BIT = 12;

  localparam logic [WORD_W-1:0] NOP_WORD = 64'h0000_0000_0000_0000;
  localparam logic [UADDR_W-1:0] RESET_UADDR = 13'h0000;

  // store load port targets
  localparam logic [1:0] SEL_PROM = 2'h0;
  localparam logic [1:0] SEL_WCS = 2'h1;
  localparam logic [1:0] SEL_MAP = 2'h2;

  typedef enum logic [3:0] {
    OP_CONT,
    OP_JUMP,
    OP_CJUMP,
    OP_CALL,
    OP_CCALL,
    OP_RET,
    OP_CRET,
    OP_MAPJ,
    OP_HOLD
  } seq_op_e;
endpackage

// ===== verilog/return_stack.sv
// microcode return-address stack, shift-register style
// assumes push and pop are never asserted together
`timescale 1ns/100ps
`default_nettype none
module return_stack
  import useq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [UADDR_W-1:0] push_data_in,
  output logic [UADDR_W-1:0] top_out
);
  logic [UADDR_W-1:0] entry [0:STACK_DEPTH-1];
  logic [UADDR_W-1:0] next_entry [0:STACK_DEPTH-1];

  assign top_out = entry[0];

  genvar i;
  generate
    for (i = 0; i < STACK_DEPTH; i++)
    begin : g_entry
      always_comb
      begin
        next_entry[i] = entry[i];
        if (push_in)
          next_entry[i] = (i == 0) ? push_data_in : entry[(i == 0) ? 0 : i-1];
        else if (pop_in)
          // bottom slot refills with zero: an underflow returns address zero
          next_entry[i] = (i == STACK_DEPTH-1) ? RESET_UADDR
                          : entry[(i == STACK_DEPTH-1) ? i : i+1];
      end

      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          entry[i] <= RESET_UADDR;
        else
          entry[i] <= next_entry[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== bench/datapath_model.sv
// datapath stand-in: instruction loads and status flags
// assumes decoded line 1 asks for an instruction load
`timescale 1ns/100ps
`default_nettype none
module datapath_model
  import useq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic [DEC_LINES-1:0] dec_in,
  input wire logic [15:0] instr_in,
  input wire logic [STATUS_W-1:0] flags_in,
  output logic [15:0] bus_out,
  output logic load_out,
  output logic [STATUS_W-1:0] status_out
);
  // ----
  // load request
  // ----
  logic next_load;
  always_comb next_load = tick_in & dec_in[1];
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) load_out <= 1'b0;
    else load_out <= next_load;
  // inverted off-load so a stale sample never matches
  assign bus_out = load_out ? instr_in : ~instr_in;
  assign status_out = flags_in;
endmodule
`default_nettype wire

// ===== bench/useq_sva.sv
// checker: microcycle pacing, held outputs, reset state
// assumes binding to the sequencer top, one clock
`timescale 1ns/100ps
`default_nettype none
module useq_sva
  import useq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic instr_load_in,
  input wire logic [15:0] internal_word_bus_in,
  input wire logic [DIRECT_W-1:0] direct_ctl_out,
  input wire logic [DEC_LINES-1:0] decoded_ctl_out,
  input wire logic [UADDR_W-1:0] uaddr_out,
  input wire logic [10:0] instruction_register_out,
  input wire logic microcycle_out
);
  // ----
  // checks
  // ----
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] gap;
  logic [5:0] next_gap;
  always_comb next_gap = microcycle_out ? 6'h00 : gap + 6'h01;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) gap <= 6'h00;
    else gap <= next_gap;
  sequence tick_s;
    microcycle_out ##1 !microcycle_out;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) rst_in |->
    uaddr_out == 13'h0000 && direct_ctl_out == '0 && !microcycle_out)
    else $error("outputs not cleared in reset");
  a_first_tick: assert property ($fell(rst_in) |-> ##[0:2] microcycle_out)
    else $error("no fetch right after reset");
  a_output_stand: assert property (!microcycle_out |->
    $stable(uaddr_out) && $stable(direct_ctl_out) && $stable(decoded_ctl_out))
    else $error("outputs moved inside a microcycle");
  a_pulse_one: assert property (microcycle_out |-> tick_s)
    else $error("microcycle pulse too long");
  a_cycle_period: assert property (microcycle_out |->
    gap inside {6'h00, 6'h01, 6'h1d, 6'h25})
    else $error("microcycle length wrong");
  a_gap_max: assert property (gap <= 6'h25)
    else $error("microcycle overran");
  a_decode_hot: assert property (microcycle_out |-> $onehot(decoded_ctl_out))
    else $error("decoded lines not one-hot");
  a_ir_load: assert property (instr_load_in |=>
    instruction_register_out == 11'($past(internal_word_bus_in)))
    else $error("instruction register not loaded");
endmodule
`default_nettype wire

// ===== bench/tb.sv
// testbench: microprogram walk, fast-speed reset, option stores and ops
// assumes the datapath model issues loads and status
`timescale 1ns/100ps
`default_nettype none
module tb
  import useq_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b0;
  logic fast = 1'b0;
  logic ring = 1'b0;
  logic ext = 1'b0;
  logic wfit = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] wr_sel = 2'h0;
  logic [11:0] wr_addr = 12'h000;
  logic [WORD_W-1:0] wr_data = '0;
  logic [15:0] bus;
  logic load;
  logic [STATUS_W-1:0] status;
  logic [DIRECT_W-1:0] dir;
  logic [DEC_LINES-1:0] dcd;
  logic [UADDR_W-1:0] ua;
  logic [10:0] ir;
  logic mc;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [12:0] pa [7] = '{13'h0, 13'h5, 13'ha, 13'h6, 13'h14, 13'h15, 13'h123};
  logic [12:0] ex [7] = '{13'h5, 13'ha, 13'h6, 13'h14, 13'h15, 13'h123,
    13'h124};
  seq_op_e op [7] = '{OP_JUMP, OP_CALL, OP_RET, OP_CJUMP, OP_CJUMP, OP_MAPJ,
    OP_CONT};
  logic [2:0] dec [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h5};
  always #2.5 clk_in = ~clk_in;
  microprogram_sequencer_control microprogram_sequencer_control_inst (
    .clk_in(clk_in), .rst_in(rst_in), .speed_fast_in(fast),
    .extended_instruction_option_in(ext), .wcs_fitted_in(wfit),
    .internal_word_bus_in(bus), .instr_load_in(load), .ring_msb_in(ring),
    .status_in(status), .store_wr_en_in(wr_en), .store_wr_sel_in(wr_sel),
    .store_wr_addr_in(wr_addr), .store_wr_data_in(wr_data),
    .direct_ctl_out(dir), .decoded_ctl_out(dcd), .uaddr_out(ua),
    .instruction_register_out(ir), .microcycle_out(mc));
  datapath_model datapath_model_inst (.clk_in(clk_in), .rst_in(rst_in),
    .tick_in(mc), .dec_in(dcd), .instr_in(16'h0a40), .flags_in(16'h0008),
    .bus_out(bus), .load_out(load), .status_out(status));
  // ----
  // tasks
  // ----
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [1:0] sel, logic [11:0] a, logic [63:0] d);
    wr_sel <= sel;
    wr_addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
  endtask
  // waits for the next microcycle pulse; n is clocks between pulses less 1
  task automatic step(output int n);
    n = 0;
    @(posedge clk_in);
    while (mc !== 1'b1 && n < 100)
    begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask
  task automatic test_walk();
    int n;
    for (int i = 0; i < 7; i++)
      wr(SEL_PROM, pa[i][11:0], {op[i], 4'h3, 1'(i == 4),
        ((i == 4) ? 13'h1e : ex[i]), dec[i], 39'(pa[i])});
    wr(SEL_MAP, 12'h029, 64'h123);
    wr_en <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      step(n);
      check("uaddr", ua, ex[i]);
      check("direct", dir, pa[i]);
      check("decoded", dcd, 8'h01 << dec[i]);
      if (i > 0) check("period", n, 37);
      if (i == 5) check("ir", ir, 11'h240);
    end
    $display("test_walk done");
  endtask
  task automatic test_fast_reset();
    int n;
    @(posedge clk_in);
    fast <= 1'b1;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("rst uaddr", ua, 13'h0);
    check("rst decoded", dcd, 8'h00);
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    step(n);
    check("restart", ua, 13'h5);
    repeat (2) step(n);
    check("fast period", n, 29);
    check("return", ua, 13'h6);
    $display("test_fast_reset done");
  endtask
  // upper prom half, wcs space, upper map table, conditional call/return, hold
  task automatic test_options();
    int n;
    logic [12:0] oa [8] = '{13'h0, 13'h800, 13'h801, 13'h1005, 13'h1, 13'h2,
      13'h3, 13'h3};
    logic [12:0] ox [8] = '{13'h800, 13'h801, 13'h1005, 13'h1, 13'h2, 13'h3,
      13'h3, 13'h3};
    seq_op_e oo [7] = '{OP_CCALL, OP_CCALL, OP_JUMP, OP_CRET, OP_MAPJ,
      OP_CRET, OP_HOLD};
    @(posedge clk_in);
    rst_in <= 1'b1;
    ring <= 1'b1;
    ext <= 1'b1;
    wfit <= 1'b1;
    for (int i = 0; i < 7; i++)
      wr(oa[i][12] ? SEL_WCS : SEL_PROM, oa[i][11:0], {oo[i], 4'h3,
        1'(i == 1 || i == 5), ((i == 1) ? 13'h7ff : ox[i]), 3'h0,
        39'(oa[i])});
    wr(SEL_MAP, 12'h400, 64'h002);
    wr_en <= 1'b0;
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      step(n);
      check("opt uaddr", ua, ox[i]);
      check("opt direct", dir, oa[i]);
      check("opt decoded", dcd, 8'h01);
      if (i > 1) check("opt period", n, 29);
    end
    $display("test_options done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    // reset edge at time zero so outputs are cleared before the first clock
    rst_in <= 1'b1;
    test_walk();
    test_fast_reset();
    test_options();
    final_report();
  end
endmodule
bind microprogram_sequencer_control useq_sva useq_sva_inst (
  .clk_in(clk_in), .rst_in(rst_in), .instr_load_in(instr_load_in),
  .internal_word_bus_in(internal_word_bus_in),
  .direct_ctl_out(direct_ctl_out), .decoded_ctl_out(decoded_ctl_out),
  .uaddr_out(uaddr_out), .instruction_register_out(instruction_register_out),
  .microcycle_out(microcycle_out));
`default_nettype wire
